// >>> hdl/timer_io_cfg.svh
`ifndef TIMER_IO_CFG_SVH
`define TIMER_IO_CFG_SVH

// field positions inside an i/o control register
`define FLD_B_HI        7
`define FLD_B_LO        4
`define FLD_A_HI        3
`define FLD_A_LO        0
`define FLD_CAP_BIT     3
`define FLD_INIT_BIT    2
`define FLD_ALT_B_BIT   1
`define FIELD_RESET     4'h0
`define IOC_RESET       8'h00

// compare-match pin actions (low two bits of a field)
`define ACT_NONE        2'h0
`define ACT_LOW         2'h1
`define ACT_HIGH        2'h2
`define ACT_TOGGLE      2'h3
// capture edge selections (low two bits of a capture field)
`define EDGE_RISE       2'h0
`define EDGE_FALL       2'h1

// apb byte offsets
`define OFF_CH1_IOC     8'h00
`define OFF_CH2_IOC     8'h04
`define OFF_CH1_GRA     8'h08
`define OFF_CH1_GRB     8'h0C
`define OFF_CH2_GRA     8'h10
`define OFF_CH2_GRB     8'h14
`define OFF_STATUS      8'h18
`define OFF_MASK        8'h1C
`define WORD_ALIGN_MASK 8'h03

// status and mask bit positions
`define ST_CH1A         0
`define ST_CH1B         1
`define ST_CH2A         2
`define ST_CH2B         3
`define ST_WIDTH        4
`define ST_RESET        4'h0

`endif

// >>> hdl/timer_io_pkg.sv
`default_nettype none
package timer_io_pkg;

   // which general register a field belongs to; decoding differs per slot
   typedef enum logic [1:0] {
      slot_ch1_a = 2'h0,
      slot_ch1_b = 2'h1,
      slot_ch2   = 2'h2
   } slot_e;

   // decoded behaviour of one general register
   typedef struct packed {
      logic       out_en;
      logic       init_level;
      logic [1:0] action;
      logic       cap_rise;
      logic       cap_fall;
      logic       cap_alt;
   } mode_s;

endpackage
`default_nettype wire

// >>> hdl/gen_reg_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_io_cfg.svh"

module gen_reg_unit #(
   parameter int WIDTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] count,
   input  wire logic             out_en,
   input  wire logic             init_level,
   input  wire logic [1:0]       action,
   input  wire logic             cap_rise,
   input  wire logic             cap_fall,
   input  wire logic             cap_alt,
   input  wire logic             cfg_load,
   input  wire logic             alt_event,
   input  wire logic             pin_raw,
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wr_data,
   output logic      [WIDTH-1:0] gen_reg,
   output logic                  pin_out,
   output logic                  pin_oe,
   output logic                  event_pulse
);

   logic sync1;
   logic sync2;
   logic sync3;
   logic level;
   logic eq_d;

   // a pin change counts once the second and third stages agree
   wire next_level = (sync2 == sync3) ? sync3 : level;
   wire rise       = next_level & ~level;
   wire fall       = ~next_level & level;
   wire cap_mode   = cap_rise | cap_fall | cap_alt;
   wire cap_hit    = (cap_rise & rise) | (cap_fall & fall) | (cap_alt & alt_event);
   wire eq         = (count == gen_reg);
   // match only on the cycle the counter arrives at the register value
   wire cmp_hit    = ~cap_mode & eq & ~eq_d;

   // three-stage pin synchroniser and filtered level
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         level <= 1'b0;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2;
         level <= next_level;
      end
   end

   // general register: capture beats a software write in the same cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         gen_reg <= {WIDTH{1'b1}};
      end else if (cap_hit) begin
         gen_reg <= count;
      end else if (wr_en) begin
         gen_reg <= wr_data;
      end
   end

   // compare history and event strobe
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         eq_d        <= 1'b1;
         event_pulse <= 1'b0;
      end else begin
         eq_d        <= eq;
         event_pulse <= cap_hit | cmp_hit;
      end
   end

   // pin drive: initial level on configuration, then the match action
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         pin_oe <= out_en;
         if (cfg_load && out_en) begin
            pin_out <= init_level;
         end else if (cmp_hit && out_en) begin
            unique case (action)
               `ACT_LOW:    pin_out <= 1'b0;
               `ACT_HIGH:   pin_out <= 1'b1;
               `ACT_TOGGLE: pin_out <= ~pin_out;
               default:     pin_out <= pin_out;
            endcase
         end
      end
   end

endmodule // gen_reg_unit
`default_nettype wire

// >>> hdl/timer_ch1_ch2_io_control.sv
// What this block does
// - eight-bit control, high nibble B, low nibble A
// - zero field: compare, pin off, reset value
// - 0001-0011: start low, then low/high/toggle
// - 0100 off; 0101-0111: start high, low/high/toggle
// - 1000: capture on own pin rising edge
// - 1001: capture on own pin falling edge
// - 1010 and 1011: capture on both edges
// - channel 1 A, 11xx: capture on chan0 A event
// - channel 1 B, 1100/1101: capture on chan0 C event
// - channel 2, 11xx: same as 10xx pin capture
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "timer_io_cfg.svh"

module timer_ch1_ch2_io_control
   import timer_io_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic [7:0]       paddr,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [WIDTH-1:0] chan1_count,
   input  wire logic [WIDTH-1:0] chan2_count,
   input  wire logic             chan0_reg_a_event,
   input  wire logic             chan0_reg_c_event,
   input  wire logic             chan1_pin_a_in,
   output logic                  chan1_pin_a_out,
   output logic                  chan1_pin_a_oe,
   input  wire logic             chan1_pin_b_in,
   output logic                  chan1_pin_b_out,
   output logic                  chan1_pin_b_oe,
   input  wire logic             chan2_pin_a_in,
   output logic                  chan2_pin_a_out,
   output logic                  chan2_pin_a_oe,
   input  wire logic             chan2_pin_b_in,
   output logic                  chan2_pin_b_out,
   output logic                  chan2_pin_b_oe,
   output logic                  irq
);

   // decode one four-bit function field for a given slot
   //   0xxx: compare; bit 2 picks the start level, low bits the match action
   //         (zero low bits leave the pin released, the match still flags)
   //   10xx: capture on the own pin; 00 rising, 01 falling, 1x both edges
   //   11xx: channel 2 repeats the pin capture choices of 10xx
   //         channel 1 a captures on every channel 0 register a event
   //         channel 1 b captures on channel 0 register c events for 110x
   //         and for 111x only flags compare matches, with the pin released
   // a 11xx field on channel 1 never looks at its pin
   // the start level is applied by the unit, not by this decode
   function automatic mode_s decode_field(input logic [3:0] f, input slot_e slot);
      mode_s m;
      m = '0;
      if (!f[`FLD_CAP_BIT]) begin
         // output compare; zero low bits keep the pin released
         m.out_en     = (f[1:0] != `ACT_NONE);
         m.init_level = f[`FLD_INIT_BIT];
         m.action     = f[1:0];
      end else if (!f[`FLD_INIT_BIT] || slot == slot_ch2) begin
         // pin capture; 11xx on channel 2 mirrors 10xx
         m.cap_rise = (f[1:0] != `EDGE_FALL);
         m.cap_fall = (f[1:0] != `EDGE_RISE);
      end else if (slot == slot_ch1_a) begin
         m.cap_alt = 1'b1;
      end else begin
         m.cap_alt = ~f[`FLD_ALT_B_BIT];
      end
      return m;
   endfunction

   // software-visible registers
   // status and mask share one layout: one bit per general register
   logic [7:0]           chan1_io_control;
   logic [7:0]           chan2_io_control;
   logic [`ST_WIDTH-1:0] status;
   logic [`ST_WIDTH-1:0] mask;

   // general register values and event strobes from the four units
   // each unit owns its register; software writes reach it through wr_en
   logic [WIDTH-1:0]     chan1_general_reg_a;
   logic [WIDTH-1:0]     chan1_general_reg_b;
   logic [WIDTH-1:0]     chan2_general_reg_a;
   logic [WIDTH-1:0]     chan2_general_reg_b;
   logic [`ST_WIDTH-1:0] events;

   // apb phase and address decode
   //   no wait states: ready rises in the cycle after setup, and a write
   //   lands at the edge where ready is seen with select and enable
   wire setup_ph  = psel & ~penable;
   wire access_ph = psel & penable & pready;
   wire wr_acc    = access_ph & pwrite;
   wire aligned   = ((paddr & `WORD_ALIGN_MASK) == 8'h00);
   wire hit_c1ioc = aligned & (paddr == `OFF_CH1_IOC);
   wire hit_c2ioc = aligned & (paddr == `OFF_CH2_IOC);
   wire hit_c1gra = aligned & (paddr == `OFF_CH1_GRA);
   wire hit_c1grb = aligned & (paddr == `OFF_CH1_GRB);
   wire hit_c2gra = aligned & (paddr == `OFF_CH2_GRA);
   wire hit_c2grb = aligned & (paddr == `OFF_CH2_GRB);
   wire hit_stat  = aligned & (paddr == `OFF_STATUS);
   wire hit_mask  = aligned & (paddr == `OFF_MASK);
   wire mapped    = hit_c1ioc | hit_c2ioc | hit_c1gra | hit_c1grb |
                    hit_c2gra | hit_c2grb | hit_stat | hit_mask;

   // write strobes, taken only at the completing access edge
   // an unmapped or unaligned address matches no strobe, so the write is dropped
   wire wr_c1ioc = wr_acc & hit_c1ioc;
   wire wr_c2ioc = wr_acc & hit_c2ioc;
   wire wr_c1gra = wr_acc & hit_c1gra;
   wire wr_c1grb = wr_acc & hit_c1grb;
   wire wr_c2gra = wr_acc & hit_c2gra;
   wire wr_c2grb = wr_acc & hit_c2grb;
   wire wr_stat  = wr_acc & hit_stat;
   wire wr_mask  = wr_acc & hit_mask;

   // field split of the two control registers
   // channel 2 uses the same split; only the decode of 11xx differs
   wire [3:0] c1a_field = chan1_io_control[`FLD_A_HI:`FLD_A_LO];
   wire [3:0] c1b_field = chan1_io_control[`FLD_B_HI:`FLD_B_LO];
   wire [3:0] c2a_field = chan2_io_control[`FLD_A_HI:`FLD_A_LO];
   wire [3:0] c2b_field = chan2_io_control[`FLD_B_HI:`FLD_B_LO];
   wire [3:0] new_a     = pwdata[`FLD_A_HI:`FLD_A_LO];
   wire [3:0] new_b     = pwdata[`FLD_B_HI:`FLD_B_LO];

   // reload the initial pin level only when a field actually changes
   // so rewriting the same value leaves a running output alone
   wire load_c1a = wr_c1ioc & (new_a != c1a_field);
   wire load_c1b = wr_c1ioc & (new_b != c1b_field);
   wire load_c2a = wr_c2ioc & (new_a != c2a_field);
   wire load_c2b = wr_c2ioc & (new_b != c2b_field);

   // modes follow the written value so the unit sees it with the load strobe
   // otherwise the start level would be taken under the old field's mode
   wire [3:0] c1a_eff = load_c1a ? new_a : c1a_field;
   wire [3:0] c1b_eff = load_c1b ? new_b : c1b_field;
   wire [3:0] c2a_eff = load_c2a ? new_a : c2a_field;
   wire [3:0] c2b_eff = load_c2b ? new_b : c2b_field;

   // decoded behaviour handed to each general register unit
   mode_s m_c1a;
   mode_s m_c1b;
   mode_s m_c2a;
   mode_s m_c2b;
   assign m_c1a = decode_field(c1a_eff, slot_ch1_a);
   assign m_c1b = decode_field(c1b_eff, slot_ch1_b);
   assign m_c2a = decode_field(c2a_eff, slot_ch2);
   assign m_c2b = decode_field(c2b_eff, slot_ch2);

   // read mux, narrow registers zero-extended
   // the value is taken at setup, so a capture during access shows next read
   wire [31:0] rd_mux =
      hit_c1ioc ? {24'h000000, chan1_io_control} :
      hit_c2ioc ? {24'h000000, chan2_io_control} :
      hit_c1gra ? 32'(chan1_general_reg_a) :
      hit_c1grb ? 32'(chan1_general_reg_b) :
      hit_c2gra ? 32'(chan2_general_reg_a) :
      hit_c2grb ? 32'(chan2_general_reg_b) :
      hit_stat  ? 32'(status) :
      hit_mask  ? 32'(mask) : 32'h00000000;

   // sticky status: a new event wins over a write-one clear
   // an event in the same cycle as its clear leaves the bit set
   wire [`ST_WIDTH-1:0] clr_bits    = wr_stat ? pwdata[`ST_WIDTH-1:0] : `ST_RESET;
   wire [`ST_WIDTH-1:0] next_status = (status & ~clr_bits) | events;

   // apb ready: one pulse, in the cycle after every setup
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_ph;
      end
   end

   // apb read data: taken at setup, held until the next setup
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
      end else if (setup_ph) begin
         prdata <= rd_mux;
      end
   end

   // apb error: unmapped or unaligned addresses are refused
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup_ph & ~mapped;
      end
   end

   // channel 1 control, reset to output-disabled fields
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         chan1_io_control <= `IOC_RESET;
      end else if (wr_c1ioc) begin
         chan1_io_control <= pwdata[7:0];
      end
   end

   // channel 2 control, reset to output-disabled fields
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         chan2_io_control <= `IOC_RESET;
      end else if (wr_c2ioc) begin
         chan2_io_control <= pwdata[7:0];
      end
   end

   // unmasked pending bits; any one of them raises the interrupt
   wire [`ST_WIDTH-1:0] pending = status & mask;

   // sticky status register
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         status <= `ST_RESET;
      end else begin
         status <= next_status;
      end
   end

   // interrupt mask, same layout as status
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mask <= `ST_RESET;
      end else if (wr_mask) begin
         mask <= pwdata[`ST_WIDTH-1:0];
      end
   end

   // level interrupt, one cycle behind status
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |pending;
      end
   end

   // channel 1 register a: pin a or channel 0 register a events
   // the unit synchronises its own pin; channel 0 strobes share this clock
   gen_reg_unit #(.WIDTH(WIDTH)) u_c1a (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .count       (chan1_count),
      .out_en      (m_c1a.out_en),
      .init_level  (m_c1a.init_level),
      .action      (m_c1a.action),
      .cap_rise    (m_c1a.cap_rise),
      .cap_fall    (m_c1a.cap_fall),
      .cap_alt     (m_c1a.cap_alt),
      .cfg_load    (load_c1a),
      .alt_event   (chan0_reg_a_event),
      .pin_raw     (chan1_pin_a_in),
      .wr_en       (wr_c1gra),
      .wr_data     (pwdata[WIDTH-1:0]),
      .gen_reg     (chan1_general_reg_a),
      .pin_out     (chan1_pin_a_out),
      .pin_oe      (chan1_pin_a_oe),
      .event_pulse (events[`ST_CH1A])
   );

   // channel 1 register b: pin b or channel 0 register c events
   // 111x leaves this register with neither capture nor pin drive
   gen_reg_unit #(.WIDTH(WIDTH)) u_c1b (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .count       (chan1_count),
      .out_en      (m_c1b.out_en),
      .init_level  (m_c1b.init_level),
      .action      (m_c1b.action),
      .cap_rise    (m_c1b.cap_rise),
      .cap_fall    (m_c1b.cap_fall),
      .cap_alt     (m_c1b.cap_alt),
      .cfg_load    (load_c1b),
      .alt_event   (chan0_reg_c_event),
      .pin_raw     (chan1_pin_b_in),
      .wr_en       (wr_c1grb),
      .wr_data     (pwdata[WIDTH-1:0]),
      .gen_reg     (chan1_general_reg_b),
      .pin_out     (chan1_pin_b_out),
      .pin_oe      (chan1_pin_b_oe),
      .event_pulse (events[`ST_CH1B])
   );

   // channel 2 register a: pin capture only
   // no channel 0 source here, so the alternate event is held low
   gen_reg_unit #(.WIDTH(WIDTH)) u_c2a (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .count       (chan2_count),
      .out_en      (m_c2a.out_en),
      .init_level  (m_c2a.init_level),
      .action      (m_c2a.action),
      .cap_rise    (m_c2a.cap_rise),
      .cap_fall    (m_c2a.cap_fall),
      .cap_alt     (m_c2a.cap_alt),
      .cfg_load    (load_c2a),
      .alt_event   (1'b0),
      .pin_raw     (chan2_pin_a_in),
      .wr_en       (wr_c2gra),
      .wr_data     (pwdata[WIDTH-1:0]),
      .gen_reg     (chan2_general_reg_a),
      .pin_out     (chan2_pin_a_out),
      .pin_oe      (chan2_pin_a_oe),
      .event_pulse (events[`ST_CH2A])
   );

   // channel 2 register b: pin capture only
   // same decode as register a of this channel
   gen_reg_unit #(.WIDTH(WIDTH)) u_c2b (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .count       (chan2_count),
      .out_en      (m_c2b.out_en),
      .init_level  (m_c2b.init_level),
      .action      (m_c2b.action),
      .cap_rise    (m_c2b.cap_rise),
      .cap_fall    (m_c2b.cap_fall),
      .cap_alt     (m_c2b.cap_alt),
      .cfg_load    (load_c2b),
      .alt_event   (1'b0),
      .pin_raw     (chan2_pin_b_in),
      .wr_en       (wr_c2grb),
      .wr_data     (pwdata[WIDTH-1:0]),
      .gen_reg     (chan2_general_reg_b),
      .pin_out     (chan2_pin_b_out),
      .pin_oe      (chan2_pin_b_oe),
      .event_pulse (events[`ST_CH2B])
   );

endmodule // timer_ch1_ch2_io_control
`default_nettype wire

// >>> tb/timer_io_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_io_cfg.svh"
// bus answer, pin enable and interrupt relations at the block's ports
module timer_io_asserts (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        chan1_pin_a_oe,
   input wire logic        chan2_pin_b_oe,
   input wire logic        irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // bus phases
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_wr(logic [7:0] a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence
   AST_READY_AFTER_SETUP:
      assert property (s_setup |=> pready) else $error("no ready after setup");
   AST_READY_PULSE:
      assert property (pready |=> !pready) else $error("ready held too long");
   AST_ERR_WITH_READY:
      assert property (pslverr |-> pready) else $error("error without ready");
   AST_ERR_ADDR:
      assert property (s_setup ##0 (paddr[1:0] != 2'h0 || paddr > `OFF_MASK) |=> pslverr)
         else $error("bad address not refused");
   AST_ERR_READ_ZERO:
      assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
   AST_CTRL_UPPER_ZERO:
      assert property (pready && !pwrite && (paddr == `OFF_CH1_IOC || paddr == `OFF_CH2_IOC)
         |-> prdata[31:8] == 24'h0) else $error("control upper bits set");
   AST_OE_OFF_CH1A:
      assert property (s_wr(`OFF_CH1_IOC) ##0 (pwdata[3] || pwdata[1:0] == 2'h0) |-> ##[1:2] !chan1_pin_a_oe)
         else $error("pin a drive not released");
   AST_OE_ON_CH1A:
      assert property (s_wr(`OFF_CH1_IOC) ##0 (!pwdata[3] && pwdata[1:0] != 2'h0) |-> ##[1:2] chan1_pin_a_oe)
         else $error("pin a drive not enabled");
   AST_OE_ON_CH2B:
      assert property (s_wr(`OFF_CH2_IOC) ##0 (!pwdata[7] && pwdata[5:4] != 2'h0) |-> ##[1:2] chan2_pin_b_oe)
         else $error("pin b drive not enabled");
   AST_IRQ_MASKED:
      assert property (s_wr(`OFF_MASK) ##0 pwdata[3:0] == 4'h0 |-> ##2 !irq) else $error("masked irq high");
   AST_RESET_QUIET:
      assert property ($fell(sys_rst) |-> !pready && !irq && !chan1_pin_a_oe && !chan2_pin_b_oe)
         else $error("outputs active after reset");
endmodule // timer_io_asserts

bind timer_ch1_ch2_io_control timer_io_asserts i_chk (.mclk, .sys_rst, .paddr, .psel, .penable, .pwrite,
   .pwdata, .prdata, .pready, .pslverr, .chan1_pin_a_oe, .chan2_pin_b_oe, .irq);
`default_nettype wire

// >>> tb/pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// the four timer pins as the board sees them
module pin_model (
   input  wire logic [3:0] oe,
   input  wire logic [3:0] drv,
   input  wire logic [3:0] far_level,
   output logic      [3:0] pin_level
);
   // the block wins a pin while it drives it, else the far side sets it
   assign pin_level = (oe & drv) | (~oe & far_level);
endmodule // pin_model
`default_nettype wire

// >>> tb/timer_ch1_ch2_io_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_io_cfg.svh"
module timer_ch1_ch2_io_control_test;
   logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, ev_a, ev_c, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] cnt, c0;
   logic [3:0]  oe, drv, far, pins;
   logic [16:0] r;
   int          err_total, total_checks, cycles, i, n;
   // rows: field, pin enabled, start level
   localparam logic [5:0] OUT_ROWS [8] = '{6'h06, 6'h17, 6'h0A, 6'h1B, 6'h0E, 6'h1F, 6'h10, 6'h00};
   // rows: chan2, control, pin, stimulus, status expected
   localparam logic [16:0] CAP_ROWS [19] = '{17'h00801, 17'h00810, 17'h00911, 17'h00900, 17'h00A11,
      17'h00B01, 17'h00C21, 17'h00C00, 17'h00F21, 17'h0C032, 17'h0D020, 17'h0D032, 17'h08042,
      17'h10C84, 17'h1D0D8, 17'h1E0C8, 17'h10E94, 17'h10F84, 17'h0E030};
   localparam logic [3:0] CMP_V [3] = '{4'h2, 4'h5, 4'h3};

   timer_ch1_ch2_io_control #(.WIDTH(16)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan1_count(cnt), .chan2_count(cnt), .chan0_reg_a_event(ev_a), .chan0_reg_c_event(ev_c),
      .chan1_pin_a_in(pins[0]), .chan1_pin_a_out(drv[0]), .chan1_pin_a_oe(oe[0]),
      .chan1_pin_b_in(pins[1]), .chan1_pin_b_out(drv[1]), .chan1_pin_b_oe(oe[1]),
      .chan2_pin_a_in(pins[2]), .chan2_pin_a_out(drv[2]), .chan2_pin_a_oe(oe[2]),
      .chan2_pin_b_in(pins[3]), .chan2_pin_b_out(drv[3]), .chan2_pin_b_oe(oe[3]), .irq(irq));
   pin_model i_pins (.oe(oe), .drv(drv), .far_level(far), .pin_level(pins));

   // clock, counter and hang limit
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cnt <= sys_rst ? 16'h0 : cnt + 16'h1;
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one bus transfer, held until ready is sampled
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd = prdata;
      err = pslverr;
      chk("ready", pready, 1'b1);
      psel <= 1'b0; penable <= 1'b0;
   endtask

   initial begin
      {sys_rst, psel, penable, pwrite, ev_a, ev_c} = 6'h20;
      paddr = 8'h00; pwdata = 32'h0; far = 4'h0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      apb(0, `OFF_CH1_IOC, 0); chk("ctrl reset", rd, 32'h0);
      apb(0, `OFF_CH1_GRA, 0); chk("reg reset", rd, 32'h0000FFFF);
      chk("pins off", oe, 4'h0);
      apb(1, `OFF_CH1_IOC, 32'h10);
      repeat (3) @(posedge mclk);
      chk("nibble split", oe[1:0], 2'h2);
      for (i = 0; i < 8; i++) begin
         apb(1, `OFF_CH1_IOC, {24'h0, {2{OUT_ROWS[i][5:2]}}});
         apb(1, `OFF_CH2_IOC, {24'h0, {2{OUT_ROWS[i][5:2]}}});
         repeat (3) @(posedge mclk);
         chk("pin enable", oe, {4{OUT_ROWS[i][1]}});
         if (OUT_ROWS[i][1]) chk("start level", drv, {4{OUT_ROWS[i][0]}});
         apb(0, `OFF_CH2_IOC, 0); chk("ctrl readback", rd, {24'h0, {2{OUT_ROWS[i][5:2]}}});
      end
      // compare actions: the pin leaves its start level at the match
      for (i = 0; i < 3; i++) begin
         c0 = cnt + 16'd40;
         apb(1, `OFF_CH1_GRA, {16'h0, c0});
         apb(1, `OFF_CH1_IOC, {28'h0, CMP_V[i]});
         repeat (3) @(posedge mclk);
         n = 0;
         while (drv[0] === CMP_V[i][2] && n < 80) begin
            @(negedge mclk);
            n++;
         end
         chk("match time", cnt, c0 + 16'h1);
         chk("match level", drv[0], !CMP_V[i][2]);
      end
      // capture value and interrupt
      apb(1, `OFF_MASK, 32'h1);
      apb(1, `OFF_CH1_IOC, 32'h08);
      repeat (8) @(posedge mclk);
      apb(1, `OFF_STATUS, 32'hF);
      repeat (2) @(posedge mclk);
      far[0] <= 1'b1;
      c0 = cnt + 16'd4;
      n = 0;
      while (irq !== 1'b1 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      chk("irq", irq, 1'b1);
      apb(0, `OFF_CH1_GRA, 0); chk("captured count", rd, {16'h0, c0});
      apb(1, `OFF_STATUS, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq cleared", irq, 1'b0);
      apb(1, `OFF_MASK, 32'h0);
      // capture sources per field value
      for (i = 0; i < 19; i++) begin
         r = CAP_ROWS[i];
         apb(1, r[16] ? `OFF_CH2_IOC : `OFF_CH1_IOC, {24'h0, r[15:8]});
         @(posedge mclk);
         far[r[7:6]] <= r[4];
         repeat (8) @(posedge mclk);
         apb(1, `OFF_STATUS, 32'hF);
         @(posedge mclk);
         if (r[5]) {ev_c, ev_a} <= {r[4], ~r[4]};
         else far[r[7:6]] <= ~r[4];
         @(posedge mclk);
         {ev_c, ev_a} <= 2'h0;
         repeat (8) @(posedge mclk);
         apb(0, `OFF_STATUS, 0); chk("status", rd[3:0], r[3:0]);
      end
      chk("masked irq", irq, 1'b0);
      apb(0, 8'h20, 0); chk("unmapped err", err, 1'b1); chk("unmapped data", rd, 32'h0);
      apb(1, 8'h02, 32'hFF); chk("unaligned", err, 1'b1);
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      apb(0, `OFF_CH1_IOC, 0); chk("ctrl after reset", rd, 32'h0);
      wrap_up();
   end
endmodule // timer_ch1_ch2_io_control_test
`default_nettype wire
